// file: rtl/dle_latch_edge.sv
// latch edge select: apb registers, config crossing, capture strobe logic
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "dle_defines.svh"

module dle_latch_edge (
  // system side
  input wire logic sys_clk,
  input wire logic resetn,
  // register bus
  input wire dle_pkg::dle_apb_req_s apb_req,
  output dle_pkg::dle_apb_rsp_s apb_rsp,
  // data link
  input wire logic conversion_clock,
  input wire dle_pkg::dle_word_t data_in,
  output logic capture_strobe,
  output dle_pkg::dle_word_t capture_word,
  output dle_pkg::dle_word_t sample_out,
  // input rate clock pin
  input wire logic input_rate_clock_pin,
  output logic input_rate_clock_drv,
  output logic input_rate_clock_en
);
  import dle_pkg::*;

  // ============================================================
  // state
  dle_sys_s s_reg;
  dle_sys_s s_next;
  dle_link_s l_reg;
  dle_link_s l_next;
  dle_word_t fall_word_reg;
  logic [1:0] lrst_reg;
  logic link_rst_n;

  // ============================================================
  // apb slave
  logic [7:0] idx;
  logic hit;
  logic setup;
  logic wr;
  logic [31:0] rd_val;

  assign idx = apb_req.paddr[`DLE_IDX_HI:`DLE_IDX_LO];
  assign hit = (idx == `DLE_IDX_SEL) || (idx == `DLE_IDX_CTL_A) ||
               (idx == `DLE_IDX_CTL_B) || (idx == `DLE_IDX_STAT);
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

  always_comb begin
    rd_val = 32'h0;
    case (idx)
      `DLE_IDX_SEL: begin
        rd_val[`DLE_SEL_HI:`DLE_SEL_LO] = s_reg.cfg.sel;
      end
      `DLE_IDX_CTL_A: begin
        rd_val[`DLE_POL_BIT] = s_reg.cfg.pol;
        rd_val[`DLE_MASTER_BIT] = s_reg.cfg.master;
        rd_val[`DLE_RECOV_BIT] = s_reg.cfg.recov;
      end
      `DLE_IDX_CTL_B: begin
        rd_val[`DLE_OFS_HI:`DLE_OFS_LO] = s_reg.cfg.ofs;
        rd_val[`DLE_MODSYNC_BIT] = s_reg.cfg.modsync;
      end
      `DLE_IDX_STAT: begin
        rd_val[`DLE_ST_PEND] = s_reg.dirty || (s_reg.hs == DLE_WAIT);
        rd_val[`DLE_ST_ACT] = s_reg.act_sync[1];
        rd_val[`DLE_ST_EXT] = !s_reg.cfg.master && !s_reg.cfg.modsync &&
                              !s_reg.cfg.recov;
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  // zero wait states: read data is caught in the setup cycle
  assign apb_rsp.prdata = s_reg.rdata;
  assign apb_rsp.pready = 1'h1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !hit;

  // ============================================================
  // system domain next state
  always_comb begin
    s_next = s_reg;
    s_next.ack_sync = {s_reg.ack_sync[0], l_reg.ack};
    s_next.act_sync = {s_reg.act_sync[0], l_reg.act};
    if (setup) begin
      s_next.rdata = rd_val;
    end
    // shadow stays frozen until the link side acknowledges
    case (s_reg.hs)
      DLE_IDLE: begin
        if (s_reg.dirty) begin
          s_next.shadow = s_reg.cfg;
          s_next.req = !s_reg.req;
          s_next.dirty = 1'h0;
          s_next.hs = DLE_WAIT;
        end
      end
      DLE_WAIT: begin
        if (s_reg.ack_sync[1] == s_reg.req) begin
          s_next.hs = DLE_IDLE;
        end
      end
      default: begin
        s_next.hs = DLE_IDLE;
      end
    endcase
    // a write in the launch cycle keeps dirty set
    if (wr && hit) begin
      case (idx)
        `DLE_IDX_SEL: begin
          s_next.cfg.sel = apb_req.pwdata[`DLE_SEL_HI:`DLE_SEL_LO];
          s_next.dirty = 1'h1;
        end
        `DLE_IDX_CTL_A: begin
          s_next.cfg.pol = apb_req.pwdata[`DLE_POL_BIT];
          s_next.cfg.master = apb_req.pwdata[`DLE_MASTER_BIT];
          s_next.cfg.recov = apb_req.pwdata[`DLE_RECOV_BIT];
          s_next.dirty = 1'h1;
        end
        `DLE_IDX_CTL_B: begin
          s_next.cfg.ofs = apb_req.pwdata[`DLE_OFS_HI:`DLE_OFS_LO];
          s_next.cfg.modsync = apb_req.pwdata[`DLE_MODSYNC_BIT];
          s_next.dirty = 1'h1;
        end
        default: begin
          s_next.dirty = s_next.dirty;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // link reset, released on the conversion clock
  always_ff @(posedge conversion_clock or negedge resetn) begin
    if (!resetn) begin
      lrst_reg <= 2'h0;
    end else begin
      lrst_reg <= {lrst_reg[0], 1'h1};
    end
  end
  assign link_rst_n = lrst_reg[1];

  // falling edge capture, used only for factor one with polarity 0
  always_ff @(negedge conversion_clock or negedge resetn) begin
    if (!resetn) begin
      fall_word_reg <= '0;
    end else begin
      fall_word_reg <= data_in;
    end
  end

  // ============================================================
  // link decode
  logic lk_ext;
  logic [2:0] lk_mask;
  logic [2:0] lk_half;
  logic [2:0] lk_shift;
  logic [2:0] lk_base;
  logic [2:0] lk_target;
  logic [2:0] lk_phase;

  // rate pin input is never read: with no recovery logic it has no use
  assign lk_ext = !l_reg.cfg.master && !l_reg.cfg.modsync && !l_reg.cfg.recov;

  always_comb begin
    case (l_reg.cfg.sel)
      2'h1: begin
        lk_mask = 3'h1;
        lk_half = 3'h1;
        lk_shift = {2'h0, l_reg.cfg.ofs[2]};
      end
      2'h2: begin
        lk_mask = 3'h3;
        lk_half = 3'h2;
        lk_shift = {1'h0, l_reg.cfg.ofs[2:1]};
      end
      2'h3: begin
        lk_mask = 3'h7;
        lk_half = 3'h4;
        lk_shift = l_reg.cfg.ofs[2:0];
      end
      default: begin
        lk_mask = 3'h0;
        lk_half = 3'h0;
        lk_shift = 3'h0;
      end
    endcase
    if (lk_ext) begin
      lk_shift = 3'h0;
    end
  end

  // the sign bit drops out modulo the factor
  assign lk_base = l_reg.cfg.pol ? 3'h0 : lk_half;
  assign lk_target = (lk_base + lk_shift) & lk_mask;
  assign lk_phase = (l_reg.cnt - lk_shift) & lk_mask;

  // ============================================================
  // link domain next state
  always_comb begin
    l_next = l_reg;
    l_next.req_sync = {l_reg.req_sync[0], s_reg.req};
    if (l_reg.req_sync[1] != l_reg.ack) begin
      l_next.cfg = s_reg.shadow;
      l_next.ack = !l_reg.ack;
    end
    l_next.cnt = (l_reg.cnt + 3'h1) & lk_mask;
    l_next.strobe = 1'h0;
    if (l_reg.cnt == lk_target) begin
      l_next.strobe = 1'h1;
      l_next.act = !l_reg.act;
      if (lk_mask == 3'h0 && !l_reg.cfg.pol) begin
        l_next.word = fall_word_reg;
      end else begin
        l_next.word = data_in;
      end
    end
    // hold per conversion cycle; the filter bank would sit here
    l_next.sample = l_reg.word;
    l_next.rate_oe = l_reg.cfg.master;
    l_next.rate_out = l_reg.cfg.master && (lk_mask != 3'h0) &&
                      (lk_phase < lk_half);
  end

  always_ff @(posedge conversion_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign capture_strobe = l_reg.strobe;
  assign capture_word = l_reg.word;
  assign sample_out = l_reg.sample;
  assign input_rate_clock_drv = l_reg.rate_out;
  assign input_rate_clock_en = l_reg.rate_oe;

  // ============================================================
  // checks, system domain
  a_ofs_write: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr && idx == `DLE_IDX_CTL_B |=>
      s_reg.cfg.ofs == $past(apb_req.pwdata[`DLE_OFS_HI:`DLE_OFS_LO]))
    else $error("offset field not written from bus");

  a_ofs_reset: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $rose(resetn) |-> s_reg.cfg.ofs == 4'h0 && l_reg.cfg.ofs == 4'h0)
    else $error("offset field not zero after reset");

  a_sel_write: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr && idx == `DLE_IDX_SEL |=>
      s_reg.cfg.sel == $past(apb_req.pwdata[`DLE_SEL_HI:`DLE_SEL_LO]))
    else $error("factor select not written from bus");

  a_pol_write: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr && idx == `DLE_IDX_CTL_A |=>
      s_reg.cfg.pol == $past(apb_req.pwdata[`DLE_POL_BIT]))
    else $error("polarity bit not written from bus");

  a_ofs_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !(wr && idx == `DLE_IDX_CTL_B) |=> $stable(s_reg.cfg.ofs))
    else $error("offset field changed without a write");

  // ============================================================
  // checks, link domain
  a_ext_pin_idle: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    lk_ext ##1 lk_ext |-> !input_rate_clock_en)
    else $error("rate pin driven in external sync");

  a_every_edge: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    lk_mask == 3'h0 |=> capture_strobe)
    else $error("factor one missed a capture edge");

  a_eight_gap: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    (lk_mask == 3'h7)[*2] ##0 $stable(l_reg.cfg) ##1 capture_strobe |->
      !$past(capture_strobe))
    else $error("factor eight strobes too close");

  a_pol_shift: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    lk_ext && lk_mask != 3'h0 |->
      lk_target == (l_reg.cfg.pol ? 3'h0 : lk_half))
    else $error("polarity does not move capture by half");

  a_ext_no_ofs: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    lk_ext |-> lk_shift == 3'h0)
    else $error("offset used in external sync");

  a_fall_pick: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    capture_strobe && $past(lk_mask == 3'h0 && !l_reg.cfg.pol) |->
      capture_word == $past(fall_word_reg))
    else $error("polarity 0 did not use falling edge data");

  a_strobe_phase: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    capture_strobe |-> $past(l_reg.cnt) == $past(lk_target))
    else $error("capture away from selected count");

  a_master_ofs: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    l_reg.cfg.master && lk_mask == 3'h1 |->
      lk_shift == {2'h0, l_reg.cfg.ofs[2]})
    else $error("two times offset decode wrong");

  // count may exceed a smaller mask for one cycle right after a config load
  a_cnt_wrap: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    $stable(l_reg.cfg) |-> (l_reg.cnt & ~lk_mask) == 3'h0)
    else $error("counter outside factor range");

  a_one_per_word: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    l_reg.cnt == lk_target && lk_mask != 3'h0 ##1 $stable(l_reg.cfg) |->
      l_reg.cnt != lk_target)
    else $error("capture count hit twice in a row");

  a_no_stray: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    l_reg.cnt != lk_target |=> !capture_strobe)
    else $error("strobe away from selected count");

  a_word_hold: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    l_reg.cnt != lk_target |=> $stable(capture_word))
    else $error("captured word changed without a capture");

  a_rise_pick: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    capture_strobe && $past(lk_mask != 3'h0 || l_reg.cfg.pol) |->
      capture_word == $past(data_in))
    else $error("rising edge capture took wrong data");

  a_sample_lag: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    capture_strobe |=> sample_out == $past(capture_word))
    else $error("sample output does not follow capture");

  a_rate_quiet: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    !l_reg.cfg.master |=>
      !input_rate_clock_en && !input_rate_clock_drv)
    else $error("rate pin driven outside master mode");

  a_rate_drive: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    l_reg.cfg.master |=> input_rate_clock_en)
    else $error("rate pin not driven in master mode");

  a_rate_one: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    lk_mask == 3'h0 |=> !input_rate_clock_drv)
    else $error("rate clock toggles at factor one");

  a_four_ofs: assert property (
    @(posedge conversion_clock) disable iff (!link_rst_n)
    !lk_ext && lk_mask == 3'h3 |->
      lk_shift == {1'h0, l_reg.cfg.ofs[2:1]})
    else $error("four times offset decode wrong");

endmodule

// file: rtl/dle_defines.svh
// register map, field positions and reset values of the latch edge select block
// Notes on behaviour
// - external sync: rate pin input, fully ignored
// - external sync: timing from conversion clock only
// - factor one: capture every conversion cycle
// - factors 2/4/8: capture one edge per factor
// - polarity toggle moves capture by half factor
// - external sync: offset field has no effect
// - factor one: polarity 0 falling, 1 rising
// - offset field lives in register 0x05 bits 7:4
// - offset decoded signed, -8 to +7 eighths of a factor period
// - factor eight: all sixteen offset codes valid
// - factor four: even codes only, four edges
// - factor two: codes 0,4,8,c, two edges
// - offset field resets to zero
// - master: offset moves rate clock and capture
// - two-bit factor select: none,2,4,8
// - samples leave at input rate times factor
// - polarity is register 0x02 bit 4
`ifndef DLE_DEFINES_SVH
`define DLE_DEFINES_SVH

// ============================================================
// register indices (byte address is four times the index)
`define DLE_IDX_SEL 8'h01
`define DLE_IDX_CTL_A 8'h02
`define DLE_IDX_CTL_B 8'h05
`define DLE_IDX_STAT 8'h06
`define DLE_IDX_HI 9
`define DLE_IDX_LO 2

// ============================================================
// field positions
`define DLE_SEL_HI 1
`define DLE_SEL_LO 0
`define DLE_POL_BIT 4
`define DLE_MASTER_BIT 3
`define DLE_RECOV_BIT 2
`define DLE_OFS_HI 7
`define DLE_OFS_LO 4
`define DLE_MODSYNC_BIT 3
`define DLE_ST_PEND 0
`define DLE_ST_ACT 1
`define DLE_ST_EXT 2

// ============================================================
// reset values
`define DLE_OFS_RST 4'h0
`define DLE_SEL_RST 2'h0
`define DLE_BIT_RST 1'h0

`endif

// file: rtl/dle_pkg.sv
// types shared by the latch edge select block
package dle_pkg;

  typedef logic [15:0] dle_word_t;

  typedef struct packed {
    logic pol;
    logic [3:0] ofs;
    logic [1:0] sel;
    logic master;
    logic modsync;
    logic recov;
  } dle_cfg_s;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dle_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dle_apb_rsp_s;

  typedef enum logic {DLE_IDLE, DLE_WAIT} dle_hs_e;

  typedef struct packed {
    dle_cfg_s cfg;
    dle_cfg_s shadow;
    logic dirty;
    logic req;
    logic [1:0] ack_sync;
    logic [1:0] act_sync;
    logic [31:0] rdata;
    dle_hs_e hs;
  } dle_sys_s;

  typedef struct packed {
    dle_cfg_s cfg;
    logic [1:0] req_sync;
    logic ack;
    logic [2:0] cnt;
    logic strobe;
    dle_word_t word;
    dle_word_t sample;
    logic act;
    logic rate_out;
    logic rate_oe;
  } dle_link_s;

endpackage

// file: testbench/dle_data_src.sv
// data source model driving parallel words into the latch edge block
`timescale 1ns/1ps

module dle_data_src (
  // link side
  input wire logic conversion_clock,
  input wire logic resetn,
  // words out
  output dle_pkg::dle_word_t data_in
);
  import dle_pkg::*;
  // ============================================================
  // running count: a captured word tells on which cycle it was taken
  always_ff @(posedge conversion_clock or negedge resetn) begin
    if (!resetn) begin
      data_in <= 16'h0000;
    end else begin
      data_in <= data_in + 16'h0001;
    end
  end
endmodule

// file: testbench/tb.sv
// self-checking bench for the latch edge select block
`timescale 1ns/1ps

module tb;
  import dle_pkg::*;
  logic sys_clk, resetn, conversion_clock, rate_pin, capture_strobe, rate_drv, rate_en, err;
  dle_apb_req_s req;
  dle_apb_rsp_s rsp;
  dle_word_t data_in, capture_word, sample_out, w0, w1;
  logic [31:0] rd;
  logic [3:0] codes [4] = '{4'h1, 4'h2, 4'h4, 4'hf};
  int fails, n_tests, f, k;

  dle_latch_edge DUT (.sys_clk(sys_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .conversion_clock(conversion_clock), .data_in(data_in), .capture_strobe(capture_strobe),
    .capture_word(capture_word), .sample_out(sample_out), .input_rate_clock_pin(rate_pin),
    .input_rate_clock_drv(rate_drv), .input_rate_clock_en(rate_en));
  dle_data_src SRC (.conversion_clock(conversion_clock), .resetn(resetn), .data_in(data_in));

  // ============================================================
  // clocks; link clock phase deliberately unrelated
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    conversion_clock = 0;
    #1.3;
    forever #62.5 conversion_clock = ~conversion_clock;
  end
  // junk on the rate pin must change nothing
  always begin
    repeat (7) @(posedge sys_clk);
    rate_pin <= ~rate_pin;
  end

  // ============================================================
  // tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.paddr <= {2'b00, idx, 2'b00};
    req.pwrite <= wr;
    req.pwdata <= wd;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // write, then wait until the link has taken the config
  task automatic cfg(input logic [7:0] idx, input logic [31:0] wd);
    int n;
    apb(1'b1, idx, wd);
    n = 0;
    do begin
      apb(1'b0, 8'h06, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    if (n >= 40) fails++;
    // a strobe launched under the old config may still be in flight
    repeat (2) @(negedge conversion_clock);
  endtask

  task automatic get_word(output dle_word_t w);
    int n;
    n = 0;
    do begin
      @(negedge conversion_clock);
      n++;
    end while (capture_strobe !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    w = capture_word;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    finish_test;
  end

  // ============================================================
  // main sequence
  initial begin
    req = '0;
    resetn = 0;
    rate_pin = 0;
    fails = 0;
    n_tests = 0;
    // link reset needs two link edges, so hold in link cycles
    repeat (3) @(posedge conversion_clock);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge conversion_clock);
    apb(1'b0, 8'h01, 32'h0);
    check("factor sel", 32'h0, rd);
    apb(1'b0, 8'h02, 32'h0);
    check("ctl a", 32'h0, rd);
    apb(1'b0, 8'h05, 32'h0);
    check("offset", 32'h0, rd);
    apb(1'b0, 8'h06, 32'h0);
    check("status", 32'h4, rd & 32'h5);
    apb(1'b0, 8'h03, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    cfg(8'h05, 32'hffffffff);
    apb(1'b0, 8'h05, 32'h0);
    check("offset field", 32'hf8, rd);
    cfg(8'h02, 32'h10);
    apb(1'b0, 8'h02, 32'h0);
    check("polarity bit", 32'h10, rd);
    for (k = 0; k < 2; k++) begin
      cfg(8'h02, k ? 32'h10 : 32'h0);
      get_word(w0);
      get_word(w1);
      check("x1 step", 32'h1, w1 - w0);
    end
    @(negedge conversion_clock);
    check("sample out", w1, sample_out);
    for (int s = 1; s < 4; s++) begin
      f = 1 << s;
      cfg(8'h05, 32'h0);
      cfg(8'h02, 32'h0);
      cfg(8'h01, s);
      get_word(w0);
      get_word(w1);
      check("step", f, w1 - w0);
      check("rate en ext", 32'h0, rate_en);
      cfg(8'h02, 32'h10);
      get_word(w1);
      check("pol move", f / 2, (w1 - w0) & (f - 1));
      cfg(8'h05, 32'h10);
      get_word(w1);
      check("ofs ignored", f / 2, (w1 - w0) & (f - 1));
      cfg(8'h02, 32'h08);
      check("rate en", 32'h1, rate_en);
      for (int c = 0; c < 4; c++) begin
        cfg(8'h05, {codes[c], 4'h0});
        get_word(w1);
        check("ofs shift", (codes[c] >> (3 - s)) & (f - 1), (w1 - w0) & (f - 1));
      end
      k = 0;
      repeat (f) begin
        @(negedge conversion_clock);
        if (rate_drv === 1'b1) k++;
      end
      check("rate high", f / 2, k);
    end
    cfg(8'h02, 32'h04);
    apb(1'b0, 8'h06, 32'h0);
    check("ext flag", 32'h0, rd & 32'h5);
    get_word(w1);
    check("slave ofs", 32'h7, (w1 - w0) & 32'h7);
    finish_test;
  end
endmodule
